// ---- logic/gct_timers.sv ----
/*
 * Three counter/timers with APB registers, sticky overflow status with
 * mask and level interrupt, UART bit-rate tick and suspend wake-up.
 * Assumes a single clock, inputs synchronous to it, and an APB master that
 * holds each request until pready is seen high.
 */
`timescale 1ns/1ps
`include "gct_map.svh"

module gct_timers
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_pin_zero,
    input  wire logic        event_pin_one,
    input  wire logic        external_gate_input_zero,
    input  wire logic        external_gate_input_one,
    input  wire logic        external_osc_clock,
    input  wire logic        suspend,
    output logic             irq,
    output logic             uart_bit_tick,
    output logic             wake
);
    import gct_pkg::*;

    gct_state_type s_q;
    gct_state_type s_d;

    // Advance a timer zero/one count by one in the given mode; bit 16 is overflow
    function automatic logic [16:0] step_count(input logic [15:0] c, input gct_mode_type m);
        logic [12:0] v13;
        logic [16:0] r;
        v13 = {c[15:8], c[4:0]} + 13'h0001;
        r = {1'b0, c};
        unique case (m)
            GCT_MODE_13BIT:
                r = {&{c[15:8], c[4:0]}, v13[12:5], c[7:5], v13[4:0]};
            GCT_MODE_16BIT:
                r = {&c, c + 16'h0001};
            GCT_MODE_RELOAD8:
                r = (&c[7:0]) ? {1'b1, c[15:8], c[15:8]} : {1'b0, c[15:8], c[7:0] + 8'h01};
            GCT_MODE_SPLIT8:
                r = {&c[7:0], c[15:8], c[7:0] + 8'h01};
        endcase
        return r;
    endfunction : step_count

    // Timer-run decision shared by both standard timers
    function automatic logic run_ok(input logic run, input logic gate, input logic gin,
                                    input logic pol);
        return run & (~gate | (gin == pol));
    endfunction : run_ok

    logic        tick4;
    logic        tick12;
    logic        tick48;
    logic        tick_ext8;
    logic        pre_tick;
    logic        fall0;
    logic        fall1;
    logic        en0;
    logic        en1;
    logic        en0_high;
    logic        tick0;
    logic        tick1;
    logic        tick2;
    logic [16:0] nxt0;
    logic [16:0] nxt1;
    logic        ovf0;
    logic        ovf1;
    logic        ovf0_high;
    logic        ovf2_low;
    logic        ovf2_high;
    logic        wr;
    logic        rd;
    logic [`GCT_ST_WIDTH-1:0] set_bits;
    gct_mode_type mode0;
    gct_mode_type mode1;

    assign wr = psel & penable & s_q.pready & pwrite;
    assign rd = psel & penable & s_q.pready & ~pwrite;
    assign mode0 = gct_mode_type'(s_q.ctrl[`GCT_T0_MODE_LSB +: 2]);
    assign mode1 = gct_mode_type'(s_q.ctrl[`GCT_T1_MODE_LSB +: 2]);

    // Prescaler taps from one free counter over the 48-clock cycle
    assign tick4 = (s_q.pre_cnt[1:0] == 2'h3);
    assign tick12 = (s_q.pre_cnt == 6'h0B) || (s_q.pre_cnt == 6'h17) ||
                    (s_q.pre_cnt == 6'h23) || (s_q.pre_cnt == 6'h2F);
    assign tick48 = (s_q.pre_cnt == 6'(`GCT_DIV48 - 1));
    // External clock over eight, from rising edges after the synchroniser
    assign tick_ext8 = s_q.ext_sync[1] & ~s_q.ext_sync[2] & (s_q.ext_div == 3'h7);

    // Shared prescaled clock
    always_comb
    begin
        unique case (s_q.ctrl[`GCT_PRESCALE_LSB +: 2])
            `GCT_PRE_DIV12: pre_tick = tick12;
            `GCT_PRE_DIV4:  pre_tick = tick4;
            `GCT_PRE_DIV48: pre_tick = tick48;
            `GCT_PRE_EXT8:  pre_tick = tick_ext8;
        endcase
    end

    // Falling edges seen on the second and third sample stages only
    assign fall0 = ~s_q.pin0_sync[1] & s_q.pin0_sync[2];
    assign fall1 = ~s_q.pin1_sync[1] & s_q.pin1_sync[2];

    // Clock choice for timers zero and one; every source, event pins and external divider included, stops in suspend
    assign tick0 = s_q.ctrl[`GCT_T0_COUNTER_BIT] ? fall0 :
                   (s_q.ctrl[`GCT_T0_CLKSEL_BIT] ? 1'b1 : pre_tick);
    assign tick1 = s_q.ctrl[`GCT_T1_COUNTER_BIT] ? fall1 :
                   (s_q.ctrl[`GCT_T1_CLKSEL_BIT] ? 1'b1 : pre_tick);
    assign en0 = ~suspend & tick0 & run_ok(s_q.ctrl[`GCT_RUN0_BIT], s_q.ctrl[`GCT_T0_GATE_BIT],
                 external_gate_input_zero, s_q.ctrl[`GCT_GATE_POL0_BIT]);
    // Timer one stands still while its run bit lends itself to timer zero's high byte
    assign en1 = ~suspend & tick1 & (mode0 != GCT_MODE_SPLIT8) & (mode1 != GCT_MODE_SPLIT8) &
                 run_ok(s_q.ctrl[`GCT_RUN1_BIT], s_q.ctrl[`GCT_T1_GATE_BIT],
                 external_gate_input_one, s_q.ctrl[`GCT_GATE_POL1_BIT]);
    // High byte of split timer zero: timer clock only, timer one's run bit
    assign en0_high = ~suspend & (mode0 == GCT_MODE_SPLIT8) & s_q.ctrl[`GCT_RUN1_BIT] &
                      (s_q.ctrl[`GCT_T0_CLKSEL_BIT] ? 1'b1 : pre_tick);

    assign nxt0 = step_count(s_q.t0_cnt, mode0);
    assign nxt1 = step_count(s_q.t1_cnt, mode1);
    assign ovf0 = en0 & nxt0[16];
    assign ovf1 = en1 & nxt1[16];
    assign ovf0_high = en0_high & (&s_q.t0_cnt[15:8]);

    // Timer two clock; only the external divider runs in suspend
    always_comb
    begin
        unique case (s_q.ctrl[`GCT_T2_CLKSEL_LSB +: 2])
            `GCT_T2_SYS:   tick2 = ~suspend;
            `GCT_T2_DIV12: tick2 = ~suspend & tick12;
            default:       tick2 = tick_ext8;
        endcase
        tick2 = tick2 & s_q.ctrl[`GCT_T2_RUN_BIT];
    end
    assign ovf2_low = tick2 & (s_q.ctrl[`GCT_T2_SPLIT_BIT] ? (&s_q.t2_cnt[7:0])
                                                           : (&s_q.t2_cnt));
    assign ovf2_high = tick2 & s_q.ctrl[`GCT_T2_SPLIT_BIT] & (&s_q.t2_cnt[15:8]);

    always_comb
    begin
        set_bits = '0;
        set_bits[`GCT_ST_T0_OVF] = ovf0;
        set_bits[`GCT_ST_T1_OVF] = ovf1;
        set_bits[`GCT_ST_T0_HIGH_OVF] = ovf0_high;
        set_bits[`GCT_ST_T2_LOW_OVF] = ovf2_low;
        set_bits[`GCT_ST_T2_HIGH_OVF] = ovf2_high;
    end

    // Next state of the whole block
    always_comb
    begin
        s_d = s_q;
        s_d.pre_cnt = (s_q.pre_cnt == 6'(`GCT_DIV48 - 1)) ? 6'h00 : s_q.pre_cnt + 6'h01;
        s_d.ext_sync = {s_q.ext_sync[1:0], external_osc_clock};
        s_d.pin0_sync = {s_q.pin0_sync[1:0], event_pin_zero};
        s_d.pin1_sync = {s_q.pin1_sync[1:0], event_pin_one};
        if (s_q.ext_sync[1] & ~s_q.ext_sync[2])
        begin
            s_d.ext_div = s_q.ext_div + 3'h1;
        end
        // Timer zero; split mode keeps the high byte for its own counter
        if (en0)
        begin
            s_d.t0_cnt = nxt0[15:0];
        end
        if (en0_high)
        begin
            s_d.t0_cnt[15:8] = s_q.t0_cnt[15:8] + 8'h01;
        end
        if (en1)
        begin
            s_d.t1_cnt = nxt1[15:0];
        end
        // Timer two with reload from its own reload register
        if (tick2)
        begin
            if (s_q.ctrl[`GCT_T2_SPLIT_BIT])
            begin
                s_d.t2_cnt[7:0] = (&s_q.t2_cnt[7:0]) ? s_q.t2_reload[7:0]
                                                     : s_q.t2_cnt[7:0] + 8'h01;
                s_d.t2_cnt[15:8] = (&s_q.t2_cnt[15:8]) ? s_q.t2_reload[15:8]
                                                       : s_q.t2_cnt[15:8] + 8'h01;
            end
            else
            begin
                s_d.t2_cnt = (&s_q.t2_cnt) ? s_q.t2_reload : s_q.t2_cnt + 16'h0001;
            end
        end
        // Two timer one overflows make one bit period
        s_d.bit_tick = 1'b0;
        if (ovf1)
        begin
            s_d.baud_half = ~s_q.baud_half;
            s_d.bit_tick = s_q.baud_half;
        end
        // Wake request held until suspend ends
        if (~suspend)
        begin
            s_d.wake = 1'b0;
        end
        else if ((ovf2_low | ovf2_high) & s_q.ctrl[`GCT_T2_WAKE_EN_BIT])
        begin
            s_d.wake = 1'b1;
        end
        // Register writes win over counting in the same cycle
        if (wr)
        begin
            unique case (paddr)
                `GCT_CTRL_OFF:      s_d.ctrl = pwdata[`GCT_CTRL_WIDTH-1:0];
                `GCT_T0_CNT_OFF:    s_d.t0_cnt = pwdata[15:0];
                `GCT_T1_CNT_OFF:    s_d.t1_cnt = pwdata[15:0];
                `GCT_T2_CNT_OFF:    s_d.t2_cnt = pwdata[15:0];
                `GCT_T2_RELOAD_OFF: s_d.t2_reload = pwdata[15:0];
                `GCT_MASK_OFF:      s_d.mask = pwdata[`GCT_ST_WIDTH-1:0];
                default:            ;
            endcase
        end
        // Read clears status, but a new event in that cycle still lands
        if (rd && paddr == `GCT_STATUS_OFF)
        begin
            s_d.status = set_bits;
        end
        else
        begin
            s_d.status = s_q.status | set_bits;
        end
        s_d.irq = |(s_d.status & s_q.mask);
        // Answer one cycle after setup, so every access takes two cycles
        s_d.pready = psel & ~penable;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (psel & ~penable)
        begin
            unique case (paddr)
                `GCT_CTRL_OFF:      s_d.prdata = 32'(s_q.ctrl);
                `GCT_T0_CNT_OFF:    s_d.prdata = {16'h0000, s_q.t0_cnt};
                `GCT_T1_CNT_OFF:    s_d.prdata = {16'h0000, s_q.t1_cnt};
                `GCT_T2_CNT_OFF:    s_d.prdata = {16'h0000, s_q.t2_cnt};
                `GCT_T2_RELOAD_OFF: s_d.prdata = {16'h0000, s_q.t2_reload};
                `GCT_STATUS_OFF:    s_d.prdata = 32'(s_q.status | set_bits);
                `GCT_MASK_OFF:      s_d.prdata = 32'(s_q.mask);
                default:            s_d.pslverr = 1'b1;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq = s_q.irq;
    assign uart_bit_tick = s_q.bit_tick;
    assign wake = s_q.wake;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Odd and even timer one overflows of one bit period
    sequence s_t1_ovf_first;
        ovf1 && !s_q.baud_half;
    endsequence
    sequence s_t1_ovf_second;
        ovf1 && s_q.baud_half;
    endsequence

    a_halt_when_stopped: assert property (
        (!s_q.ctrl[`GCT_RUN0_BIT] && mode0 != GCT_MODE_SPLIT8 && !wr) |=>
        s_q.t0_cnt == $past(s_q.t0_cnt))
        else $error("timer zero moved while stopped");
    a_reload_low_byte: assert property (
        (en1 && mode1 == GCT_MODE_RELOAD8 && s_q.t1_cnt[7:0] == 8'hFF && !wr) |=>
        (s_q.t1_cnt[7:0] == $past(s_q.t1_cnt[15:8]) && s_q.status[`GCT_ST_T1_OVF]))
        else $error("reload from high byte missing");
    a_div4_period: assert property (
        tick4 |=> (!tick4)[*3] ##1 tick4)
        else $error("divide by four period wrong");
    a_div48_period: assert property (
        tick48 |-> ##48 tick48)
        else $error("divide by forty-eight period wrong");
    a_event_count: assert property (
        (fall0 && s_q.ctrl[`GCT_T0_COUNTER_BIT] && en0 && mode0 == GCT_MODE_16BIT && !wr) |=>
        s_q.t0_cnt == $past(s_q.t0_cnt) + 16'h0001)
        else $error("falling edge not counted");
    a_system_clock_count: assert property (
        (en0 && s_q.ctrl[`GCT_T0_CLKSEL_BIT] && !s_q.ctrl[`GCT_T0_COUNTER_BIT] &&
         mode0 == GCT_MODE_16BIT && !wr) |=> s_q.t0_cnt == $past(s_q.t0_cnt) + 16'h0001)
        else $error("system clock count missed");
    a_bit_rate_tick: assert property (
        s_t1_ovf_second |=> s_q.bit_tick)
        else $error("bit tick missing after two overflows");
    a_bit_tick_pair: assert property (
        s_t1_ovf_first |=> (!s_q.bit_tick && s_q.baud_half))
        else $error("bit tick after a single overflow");
    a_t2_reload: assert property (
        (ovf2_low && !s_q.ctrl[`GCT_T2_SPLIT_BIT] && !wr) |=> s_q.t2_cnt == $past(s_q.t2_reload))
        else $error("timer two did not reload");
    a_wake_source: assert property (
        (suspend && ovf2_low && s_q.ctrl[`GCT_T2_WAKE_EN_BIT]) |=> (s_q.wake || !suspend))
        else $error("wake not raised");
    a_irq_level: assert property (
        (s_q.irq == |(s_q.status & $past(s_q.mask))))
        else $error("interrupt level wrong");

endmodule : gct_timers

// ---- include/gct_map.svh ----
/*
 * Register offsets, field positions, reset values and divider counts of the
 * counter/timer block. Assumes a 32-bit APB and byte addressing.
 */
`ifndef GCT_MAP_SVH
`define GCT_MAP_SVH

// Register byte offsets
`define GCT_CTRL_OFF        8'h00
`define GCT_T0_CNT_OFF      8'h04
`define GCT_T1_CNT_OFF      8'h08
`define GCT_T2_CNT_OFF      8'h0C
`define GCT_T2_RELOAD_OFF   8'h10
`define GCT_STATUS_OFF      8'h14
`define GCT_MASK_OFF        8'h18

// Control register fields
`define GCT_T0_MODE_LSB     0
`define GCT_T0_COUNTER_BIT  2
`define GCT_T0_GATE_BIT     3
`define GCT_T1_MODE_LSB     4
`define GCT_T1_COUNTER_BIT  6
`define GCT_T1_GATE_BIT     7
`define GCT_RUN0_BIT        8
`define GCT_RUN1_BIT        9
`define GCT_T0_CLKSEL_BIT   10
`define GCT_T1_CLKSEL_BIT   11
`define GCT_PRESCALE_LSB    12
`define GCT_GATE_POL0_BIT   14
`define GCT_GATE_POL1_BIT   15
`define GCT_T2_RUN_BIT      16
`define GCT_T2_SPLIT_BIT    17
`define GCT_T2_CLKSEL_LSB   18
`define GCT_T2_WAKE_EN_BIT  20
`define GCT_CTRL_WIDTH      21

// Status and mask bits
`define GCT_ST_T0_OVF       0
`define GCT_ST_T1_OVF       1
`define GCT_ST_T0_HIGH_OVF  2
`define GCT_ST_T2_LOW_OVF   3
`define GCT_ST_T2_HIGH_OVF  4
`define GCT_ST_WIDTH        5

// Reset values
`define GCT_CTRL_RESET      21'h000000
`define GCT_CNT_RESET       16'h0000
`define GCT_MASK_RESET      5'h00

// Prescale codes
`define GCT_PRE_DIV12       2'h0
`define GCT_PRE_DIV4        2'h1
`define GCT_PRE_DIV48       2'h2
`define GCT_PRE_EXT8        2'h3

// Timer two clock codes
`define GCT_T2_SYS          2'h0
`define GCT_T2_DIV12        2'h1

// Divider lengths, in clocks or external edges
`define GCT_DIV4            4
`define GCT_DIV12           12
`define GCT_DIV48           48
`define GCT_EXT_DIV         8

`endif

// ---- include/gct_pkg.sv ----
/*
 * Types of the counter/timer block. Assumes gct_map.svh for field widths.
 */
`include "gct_map.svh"

package gct_pkg;

    // Timer zero/one operating modes
    typedef enum logic [1:0] {
        GCT_MODE_13BIT = 2'h0,
        GCT_MODE_16BIT = 2'h1,
        GCT_MODE_RELOAD8 = 2'h2,
        GCT_MODE_SPLIT8 = 2'h3
    } gct_mode_type;

    // Whole state of the block
    typedef struct packed {
        logic [5:0]                 pre_cnt;
        logic [2:0]                 ext_div;
        logic [2:0]                 ext_sync;
        logic [2:0]                 pin0_sync;
        logic [2:0]                 pin1_sync;
        logic [`GCT_CTRL_WIDTH-1:0] ctrl;
        logic [15:0]                t0_cnt;
        logic [15:0]                t1_cnt;
        logic [15:0]                t2_cnt;
        logic [15:0]                t2_reload;
        logic [`GCT_ST_WIDTH-1:0]   status;
        logic [`GCT_ST_WIDTH-1:0]   mask;
        logic                       irq;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
        logic                       baud_half;
        logic                       bit_tick;
        logic                       wake;
    } gct_state_type;

endpackage : gct_pkg

// ---- dv/gct_far_side.sv ----
/*
 * Far-side model: falling-edge event source, free external oscillator,
 * bit tick counter. Assumes the bench clock and calls of pulse_pin.
 */
`timescale 1ns/1ps
module gct_far_side
(
    input  wire logic clk,
    output logic      event_pin_zero,
    output logic      event_pin_one,
    output logic      external_osc_clock,
    input  wire logic uart_bit_tick
);
    logic osc_ph_q;
    int   tick_count;

    // Pins idle high so that only commanded pulses fall
    initial
    begin
        event_pin_zero = 1'b1;
        event_pin_one = 1'b1;
        external_osc_clock = 1'b0;
        osc_ph_q = 1'b0;
        tick_count = 0;
    end

    // Oscillator runs free at a quarter of the system clock
    always @(posedge clk)
    begin
        osc_ph_q <= ~osc_ph_q;
        if (osc_ph_q)
            external_osc_clock <= ~external_osc_clock;
    end

    // Bit rate consumer only counts ticks
    always @(posedge clk)
    begin
        if (uart_bit_tick === 1'b1)
            tick_count <= tick_count + 1;
    end

    // Each level held two clocks, the fastest legal rate
    task automatic pulse_pin(input int n);
        repeat (n)
        begin
            @(posedge clk);
            event_pin_zero <= 1'b0;
            repeat (2) @(posedge clk);
            event_pin_zero <= 1'b1;
            @(posedge clk);
        end
    endtask : pulse_pin
endmodule : gct_far_side

// ---- dv/test_general_counter_timers.sv ----
/*
 * Self-checking bench of the counter/timer block over APB.
 * Assumes gct_timers, gct_far_side and gct_map.svh on the include path.
 */
`timescale 1ns/1ps
`include "gct_map.svh"
module test_general_counter_timers;
    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        event_pin_zero;
    logic        event_pin_one;
    logic        gate_zero;
    logic        gate_one;
    logic        external_osc_clock;
    logic        suspend;
    logic        irq;
    logic        uart_bit_tick;
    logic        wake;
    logic [31:0] rd;
    logic        err;
    int          fail_count;
    int          checked;

    gct_timers u_gct_timers (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pin_zero(event_pin_zero), .event_pin_one(event_pin_one),
        .external_gate_input_zero(gate_zero), .external_gate_input_one(gate_one),
        .external_osc_clock(external_osc_clock), .suspend(suspend), .irq(irq),
        .uart_bit_tick(uart_bit_tick), .wake(wake));

    gct_far_side u_gct_far_side (.clk(clk), .event_pin_zero(event_pin_zero),
        .event_pin_one(event_pin_one), .external_osc_clock(external_osc_clock),
        .uart_bit_tick(uart_bit_tick));

    // 20 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // Window compare, since prescaler phase is free running
    task automatic near(input string name, input logic [31:0] seen, input int exp, input int tol);
        check(name, {31'h0, (seen >= exp - tol) && (seen <= exp + tol)}, 32'h1);
    endtask : near

    task automatic finish_test();
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never answers
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic t_reset();
        apb(1'b0, `GCT_CTRL_OFF, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, `GCT_MASK_OFF, 32'h0);
        check("mask reset", rd, 32'h0);
        check("irq reset", {31'h0, irq}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask : t_reset

    task automatic t_counter();
        apb(1'b1, `GCT_T0_CNT_OFF, 32'h0);
        apb(1'b1, `GCT_CTRL_OFF, 32'h105);
        u_gct_far_side.pulse_pin(10);
        repeat (6) @(posedge clk);
        apb(1'b0, `GCT_T0_CNT_OFF, 32'h0);
        check("event count", rd, 32'hA);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
    endtask : t_counter

    // Codes 00..11 of the prescale field, then undivided clock
    task automatic t_prescale();
        logic [31:0] cfg [5] = '{32'h0101, 32'h1101, 32'h2101, 32'h3101, 32'h0501};
        int          exp [5] = '{40, 120, 10, 15, 483};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, `GCT_T0_CNT_OFF, 32'h0);
            apb(1'b1, `GCT_CTRL_OFF, cfg[i]);
            repeat (480) @(posedge clk);
            apb(1'b1, `GCT_CTRL_OFF, 32'h0);
            apb(1'b0, `GCT_T0_CNT_OFF, 32'h0);
            near("prescaled count", rd, exp[i], 2);
        end
    endtask : t_prescale

    task automatic t_reload();
        int ticks;
        apb(1'b1, `GCT_T1_CNT_OFF, 32'hA0FE);
        ticks = u_gct_far_side.tick_count;
        apb(1'b1, `GCT_CTRL_OFF, 32'hA20);
        repeat (960) @(posedge clk);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        near("bit ticks", u_gct_far_side.tick_count - ticks, 5, 1);
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b0, `GCT_T1_CNT_OFF, 32'h0);
        check("reload byte kept", {24'h0, rd[15:8]}, 32'hA0);
        apb(1'b1, `GCT_MASK_OFF, 32'h2);
        repeat (2) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("overflow flag", {31'h0, rd[1]}, 32'h1);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("flag cleared", {31'h0, rd[1]}, 32'h0);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask : t_reload

    task automatic t_gate();
        apb(1'b1, `GCT_T0_CNT_OFF, 32'h0);
        apb(1'b1, `GCT_CTRL_OFF, 32'h4509);
        repeat (100) @(posedge clk);
        apb(1'b0, `GCT_T0_CNT_OFF, 32'h0);
        check("gated count", rd, 32'h0);
        gate_zero <= 1'b1;
        repeat (100) @(posedge clk);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_T0_CNT_OFF, 32'h0);
        near("open gate count", rd, 103, 3);
        gate_zero <= 1'b0;
    endtask : t_gate

    task automatic t_modes();
        int n;
        apb(1'b1, `GCT_T0_CNT_OFF, 32'hFF1F);
        apb(1'b1, `GCT_CTRL_OFF, 32'h500);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("13 bit overflow", {31'h0, rd[0]}, 32'h1);
        apb(1'b1, `GCT_T2_RELOAD_OFF, 32'hFFF0);
        apb(1'b1, `GCT_T2_CNT_OFF, 32'hFFF0);
        apb(1'b1, `GCT_CTRL_OFF, 32'h10000);
        repeat (40) @(posedge clk);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("timer two overflow", {31'h0, rd[3]}, 32'h1);
        apb(1'b1, `GCT_T2_CNT_OFF, 32'hFFFE);
        apb(1'b1, `GCT_T2_RELOAD_OFF, 32'hFFFE);
        apb(1'b1, `GCT_CTRL_OFF, 32'h190000);
        suspend <= 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        check("wake in suspend", {31'h0, wake}, 32'h1);
        suspend <= 1'b0;
        repeat (3) @(posedge clk);
        check("wake released", {31'h0, wake}, 32'h0);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
    endtask : t_modes

    // Split timer zero on the system clock, timer two on clock over twelve
    task automatic t_split();
        apb(1'b1, `GCT_T0_CNT_OFF, 32'hFEFE);
        apb(1'b1, `GCT_CTRL_OFF, 32'h703);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_T0_CNT_OFF, 32'h0);
        check("split count", rd, 32'h0101);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("split flags", {30'h0, rd[2], rd[0]}, 32'h3);
        apb(1'b1, `GCT_T2_CNT_OFF, 32'h0);
        apb(1'b1, `GCT_CTRL_OFF, 32'h50000);
        repeat (100) @(posedge clk);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_T2_CNT_OFF, 32'h0);
        near("timer two over twelve", rd, 9, 1);
        apb(1'b1, `GCT_T2_RELOAD_OFF, 32'hFEFC);
        apb(1'b1, `GCT_T2_CNT_OFF, 32'hFEFC);
        apb(1'b1, `GCT_CTRL_OFF, 32'h70000);
        repeat (100) @(posedge clk);
        apb(1'b1, `GCT_CTRL_OFF, 32'h0);
        apb(1'b0, `GCT_STATUS_OFF, 32'h0);
        check("timer two split flags", {30'h0, rd[4:3]}, 32'h3);
    endtask : t_split

    // Guard against a hang; the whole run is about 4000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        fail_count = 0;
        checked = 0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        gate_zero = 1'b0;
        gate_one = 1'b0;
        suspend = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_counter();
        t_prescale();
        t_reload();
        t_gate();
        t_modes();
        t_split();
        finish_test();
    end
endmodule : test_general_counter_timers
